// [rtl/cwls_line_state.sv]
// line-state tracker and issue check for coherent write transactions
`timescale 1ns/1ns

module cwls_line_state (
  input  wire logic                  core_clk,
  input  wire logic                  arst_n,
  input  wire logic                  clk_en,
  input  wire logic                  snoop_filter,
  input  wire logic                  evict_write_supported,
  input  wire logic                  req_valid,
  input  wire cwls_pkg::cwls_req_t   req,
  input  wire logic                  rsp_valid,
  input  wire logic                  store_valid,
  input  wire logic                  store_full,
  output logic                       busy,
  output logic                       issue_valid,
  output cwls_pkg::cwls_issue_t      issue,
  output logic                       reject,
  output logic                       load_line,
  output cwls_pkg::cwls_state_t      line_state
);
  import cwls_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // state change tables

  // effect of a coherent store that dirties the line
  function automatic cwls_state_t store_result(input cwls_state_t s);
    case (s)
      invalid:      store_result = unique_dirty;
      unique_clean: store_result = unique_dirty;
      unique_dirty: store_result = unique_dirty;
      shared_clean: store_result = shared_dirty;
      shared_dirty: store_result = shared_dirty;
      default:      store_result = s;
    endcase
  endfunction : store_result

  function automatic logic is_dirty(input cwls_state_t s);
    is_dirty = (s == unique_dirty) || (s == shared_dirty);
  endfunction : is_dirty

  function automatic logic is_clean(input cwls_state_t s);
    is_clean = (s == unique_clean) || (s == shared_clean);
  endfunction : is_clean

  function automatic cwls_state_t expected_end(input cwls_op_t op, input cwls_state_t s,
                                               input logic sh);
    case (op)
      write_line_unique: expected_end = (s == invalid) ? invalid : shared_clean;
      write_back:        expected_end = invalid;
      write_clean:       expected_end = (sh && s == shared_dirty) ? shared_clean
                                                                  : unique_clean;
      write_evict:       expected_end = invalid;
      default:           expected_end = s;
    endcase
  endfunction : expected_end

  // alternatives that stay inside both the tables and the allocation rule
  function automatic logic hint_legal(input cwls_op_t op, input cwls_state_t s,
                                      input logic sh, input logic sf, input cwls_state_t h);
    case (op)
      write_line_unique: hint_legal = (s != invalid) && !sf && (h == invalid);
      write_clean:       hint_legal = (sh && s == unique_dirty && h == shared_clean)
                                   || (!sh && h == shared_clean);
      default:           hint_legal = 1'b0;
    endcase
  endfunction : hint_legal

  ////////////////////////////////////////////////////////////////////////////
  // request decode

  wire         req_take   = clk_en && req_valid && !busy;
  wire         store_take = clk_en && store_valid && !busy && !req_valid;
  wire         rsp_take   = clk_en && rsp_valid && busy;
  wire         is_wlu     = (req.op == write_line_unique);
  wire         fold_store = req.with_store && (req.op == write_back || req.op == write_clean);
  // a folded store from invalid must cover the whole line
  wire         fold_ok    = !fold_store || line_state != invalid || req.full_line;
  wire cwls_state_t eff_start = fold_store ? store_result(line_state) : line_state;

  wire         wlu_ok     = req.shareable && req.full_line
                          && (eff_start == invalid || is_clean(eff_start));
  wire         dirty_ok   = is_dirty(eff_start);
  wire         evict_ok   = evict_write_supported && !req.speculative
                          && (eff_start == unique_clean);
  wire         start_ok   = fold_ok && (is_wlu                   ? wlu_ok
                                      : (req.op == write_evict) ? evict_ok
                                                                : dirty_ok);
  wire cwls_state_t exp_end = expected_end(req.op, eff_start, req.shareable);
  wire cwls_state_t next_end = hint_legal(req.op, eff_start, req.shareable, snoop_filter,
                                          req.end_hint) ? req.end_hint : exp_end;
  // a partial store may only touch a line that is already valid
  wire         store_ok   = store_full || (line_state != invalid);

  ////////////////////////////////////////////////////////////////////////////
  // registers

  cwls_op_t    pend_op;
  cwls_state_t pend_end;

  // one write in flight, so nothing is outstanding when a new one issues
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      busy <= 1'b0;
      pend_op <= CWLS_RESET_OP;
      pend_end <= CWLS_RESET_STATE;
    end
    else if (req_take && start_ok)
    begin
      busy <= 1'b1;
      pend_op <= req.op;
      pend_end <= next_end;
    end
    else if (rsp_take)
    begin
      busy <= 1'b0;
    end
  end

  // state moves on the response; a dropped write_evict still answers
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      line_state <= CWLS_RESET_STATE;
    else if (rsp_take)
      line_state <= pend_end;
    else if (store_take && store_ok)
      line_state <= store_result(line_state);
  end

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      issue_valid <= 1'b0;
      issue <= '{op: CWLS_RESET_OP, end_state: CWLS_RESET_STATE};
      reject <= 1'b0;
      load_line <= 1'b0;
    end
    else if (clk_en)
    begin
      issue_valid <= req_take && start_ok;
      if (req_take && start_ok)
        issue <= '{op: req.op, end_state: next_end};
      reject <= (req_take && !start_ok) || (store_take && !store_ok);
      load_line <= rsp_take && (pend_op == write_line_unique)
                && is_clean(line_state);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  sequence s_accept;
    clk_en && req_valid && !busy && start_ok;
  endsequence

  sequence s_issued;
    issue_valid && busy;
  endsequence

  a_issue_after_accept: assert property (
    @(posedge core_clk) disable iff (!arst_n) s_accept |=> s_issued)
    else $error("accepted request not issued");

  a_wlu_full_share: assert property (
    @(posedge core_clk) disable iff (!arst_n)
    issue_valid && issue.op == write_line_unique |-> $past(req.full_line && req.shareable))
    else $error("write_line_unique issued for partial or non-shareable line");

  a_wlu_end_state: assert property (
    @(posedge core_clk) disable iff (!arst_n)
    issue_valid && issue.op == write_line_unique && $past(line_state) == invalid
    |-> issue.end_state == invalid)
    else $error("write_line_unique from invalid must end invalid");

  a_wb_unalloc: assert property (
    @(posedge core_clk) disable iff (!arst_n)
    issue_valid && issue.op == write_back |-> issue.end_state == invalid)
    else $error("write_back must leave the line unallocated");

  a_wc_alloc: assert property (
    @(posedge core_clk) disable iff (!arst_n)
    issue_valid && issue.op == write_clean |-> is_clean(issue.end_state))
    else $error("write_clean must keep a clean allocated line");

  a_evict_gate: assert property (
    @(posedge core_clk) disable iff (!arst_n)
    issue_valid && issue.op == write_evict
    |-> $past(evict_write_supported && !req.speculative && line_state == unique_clean))
    else $error("write_evict issued while not permitted");

  a_reject_hold: assert property (
    @(posedge core_clk) disable iff (!arst_n)
    clk_en && req_valid && !busy && !start_ok |=> reject && $stable(line_state) && !busy)
    else $error("illegal request not rejected or state changed");

  a_resp_update: assert property (
    @(posedge core_clk) disable iff (!arst_n)
    rsp_take |=> line_state == $past(pend_end) && !busy)
    else $error("line state not updated on response");

  a_wlu_load: assert property (
    @(posedge core_clk) disable iff (!arst_n)
    rsp_take && pend_op == write_line_unique && is_clean(line_state) |=> load_line)
    else $error("clean line not loaded on write_line_unique response");

  a_store_valid: assert property (
    @(posedge core_clk) disable iff (!arst_n)
    $past(line_state) == invalid && line_state != invalid && !$past(rsp_take)
    |-> $past(store_take && store_full))
    else $error("invalid line became valid without full-line store");

endmodule : cwls_line_state

// [rtl/cwls_pkg.sv]
// shared types for the coherent write line-state block
package cwls_pkg;

  // local cache line states
  typedef enum logic [2:0] {
    invalid,
    unique_clean,
    shared_clean,
    unique_dirty,
    shared_dirty
  } cwls_state_t;

  // coherent write transactions handled here
  typedef enum logic [1:0] {
    write_line_unique,
    write_back,
    write_clean,
    write_evict
  } cwls_op_t;

  // one request to issue a write transaction for the tracked line
  typedef struct packed {
    cwls_op_t    op;
    logic        shareable;    // region shareable with other masters
    logic        full_line;    // every byte of the line is written
    logic        speculative;  // line may come from another shareability domain
    logic        with_store;   // dirtying store and write_back or write_clean as one step
    cwls_state_t end_hint;     // preferred end state, used only if legal
  } cwls_req_t;

  // what the block hands to the transaction issuer
  typedef struct packed {
    cwls_op_t    op;
    cwls_state_t end_state;
  } cwls_issue_t;

  localparam cwls_state_t CWLS_RESET_STATE = invalid;
  localparam cwls_op_t    CWLS_RESET_OP    = write_line_unique;

endpackage : cwls_pkg

// [tb/cwls_ic_model.sv]
// interconnect model: answers each issued write after a short or a long wait
`timescale 1ns/1ns
module cwls_ic_model (
  input  wire logic core_clk,
  input  wire logic issue_valid,
  output logic      rsp_valid = 1'b0
);
  logic [3:0] cnt  = 4'h0;
  logic       slow = 1'b0;
  ////////////////////////////////////////////////////////////////////////////////
  // an evicted line is never stored here, only acknowledged
  always @(negedge core_clk)
  begin
    rsp_valid <= 1'b0;
    if (issue_valid)
    begin
      cnt  <= slow ? 4'h6 : 4'h1;
      slow <= ~slow;
    end
    else if (cnt != 4'h0)
    begin
      cnt <= cnt - 4'h1;
      if (cnt == 4'h1)
        rsp_valid <= 1'b1;
    end
  end
endmodule : cwls_ic_model

// [tb/coherent_write_line_state_tb.sv]
// self-checking bench for the coherent write line-state tracker
`timescale 1ns/1ns
module coherent_write_line_state_tb;
  import cwls_pkg::*;
  logic        core_clk = 1'b0;
  logic        arst_n = 1'b0;
  logic        sf = 1'b1;
  logic        sup = 1'b1;
  logic        ce = 1'b1;
  logic        req_valid = 1'b0;
  cwls_req_t   req = '0;
  logic        store_valid = 1'b0;
  logic        store_full = 1'b0;
  logic        rsp_valid, busy, issue_valid, reject, load_line;
  cwls_issue_t issue;
  cwls_state_t line_state;
  int          mismatches = 0;
  int          compares = 0;
  always #25 core_clk = ~core_clk;
  cwls_line_state cwls_line_state_i (.core_clk(core_clk), .arst_n(arst_n), .clk_en(ce),
    .snoop_filter(sf), .evict_write_supported(sup), .req_valid(req_valid), .req(req),
    .rsp_valid(rsp_valid), .store_valid(store_valid), .store_full(store_full), .busy(busy),
    .issue_valid(issue_valid), .issue(issue), .reject(reject), .load_line(load_line),
    .line_state(line_state));
  cwls_ic_model cwls_ic_model_i (.core_clk(core_clk), .issue_valid(issue_valid),
    .rsp_valid(rsp_valid));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    compares++;
    if (g !== e)
    begin
      mismatches++;
      $display("Error t=%0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task automatic st(input logic f, input logic rj, input cwls_state_t e);
    store_valid = 1'b1;
    store_full  = f;
    @(negedge core_clk);
    store_valid = 1'b0;
    chk(reject, rj);
    chk(line_state, e);
    @(negedge core_clk);
  endtask : st
  // one request, then wait for the answer and the response; a refusal leaves busy low
  task automatic rq(input cwls_op_t o, input logic sh, fl, sp, ws, input cwls_state_t h,
                    input logic rj, input cwls_state_t e, input logic ld);
    int n;
    req_valid = 1'b1;
    req = '{o, sh, fl, sp, ws, h};
    @(negedge core_clk);
    req_valid = 1'b0;
    chk(reject, rj);
    chk(issue_valid, !rj);
    chk(busy, !rj);
    if (!rj) chk(issue, {o, e});
    n = 0;
    while (busy !== 1'b0 && n < 20)
    begin
      @(negedge core_clk);
      n++;
    end
    chk(busy, 1'b0);
    if (!rj) chk(load_line, ld);
    chk(line_state, e);
    @(negedge core_clk);
  endtask : rq
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_wlu;
    rq(write_line_unique, 0, 1, 0, 0, invalid, 1, invalid, 0);
    rq(write_line_unique, 1, 0, 0, 0, invalid, 1, invalid, 0);
    rq(write_line_unique, 1, 1, 0, 0, unique_clean, 0, invalid, 0);
  endtask : t_wlu
  task automatic t_wb;
    rq(write_back, 1, 0, 0, 1, invalid, 1, invalid, 0);
    st(0, 1, invalid);
    rq(write_back, 1, 1, 0, 1, invalid, 0, invalid, 0);
    st(1, 0, unique_dirty);
    rq(write_back, 0, 1, 0, 0, unique_clean, 0, invalid, 0);
  endtask : t_wb
  task automatic t_we;
    st(1, 0, unique_dirty);
    rq(write_clean, 1, 1, 0, 0, invalid, 0, unique_clean, 0);
    rq(write_evict, 1, 1, 1, 0, invalid, 1, unique_clean, 0);
    sup = 1'b0;
    rq(write_evict, 1, 1, 0, 0, invalid, 1, unique_clean, 0);
    sup = 1'b1;
    rq(write_evict, 1, 1, 0, 0, unique_clean, 0, invalid, 0);
  endtask : t_we
  task automatic t_clean;
    st(1, 0, unique_dirty);
    rq(write_clean, 1, 1, 0, 0, unique_clean, 0, unique_clean, 0);
    rq(write_line_unique, 1, 1, 0, 0, invalid, 0, shared_clean, 1);
    rq(write_back, 1, 1, 0, 0, invalid, 1, shared_clean, 0);
    rq(write_evict, 1, 1, 0, 0, invalid, 1, shared_clean, 0);
    st(1, 0, shared_dirty);
    rq(write_clean, 0, 1, 0, 0, invalid, 0, unique_clean, 0);
    sf = 1'b0;
    rq(write_line_unique, 1, 1, 0, 0, invalid, 0, invalid, 1);
    st(1, 0, unique_dirty);
    rq(write_clean, 1, 1, 0, 0, shared_clean, 0, shared_clean, 0);
    st(1, 0, shared_dirty);
    rq(write_clean, 0, 1, 0, 0, shared_clean, 0, shared_clean, 0);
  endtask : t_clean
  // a full store offered while the enable is low must not be taken
  task automatic t_freeze;
    ce          = 1'b0;
    store_valid = 1'b1;
    store_full  = 1'b1;
    @(negedge core_clk);
    store_valid = 1'b0;
    ce          = 1'b1;
    chk(line_state, invalid);
    chk(reject, 1'b0);
    @(negedge core_clk);
  endtask : t_freeze
  task automatic test_done;
    if (mismatches == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : test_done
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (3) @(negedge core_clk);
    chk({busy, issue_valid, reject, load_line}, 8'h00);
    chk(line_state, invalid);
    arst_n = 1'b1;
    @(negedge core_clk);
    t_freeze();
    t_wlu();
    t_wb();
    t_we();
    t_clean();
    test_done();
  end
  // the whole sequence needs well under 400 cycles
  initial
  begin
    #100000;
    mismatches++;
    test_done();
  end
endmodule : coherent_write_line_state_tb
